// file: logic/smf_map.svh
// constants for the serial management frame slave
// Notes on behaviour
// [RULE_01] Without preamble skipping, a frame is only decoded after 32 consecutive one bits, each on its own clock.
// [RULE_02] With preamble skipping enabled, a frame that arrives with no preamble is still decoded.
// [RULE_03] The skip bit resets to zero and takes a one only after a one was written to the override bit of reg 16.
// [RULE_04] The preamble is followed by the start delimiter 0 then 1, and a frame without it is not valid.
// [RULE_05] After the delimiter a two-bit opcode follows: 10 reads a register, 01 writes one.
// [RULE_06] Opcodes 00 and 11 are invalid, and such frames are ignored with the data line left undriven.
// [RULE_07] The five-bit frame address is compared with the stored address and only a match gets a response.
// [RULE_08] A five-bit register address picks one of 32 registers as read source or write target.
// [RULE_09] Every bit on the data line, in either direction, is timed by the management clock from the master.
// [RULE_10] The management pins work whatever MAC-side interface mode the device is in.
// [RULE_11] Frames start from and return to an idle line, and idle time is not part of a frame.
// [RULE_12] On a read turnaround the device floats the line for bit one and drives zero for bit two.
// [RULE_13] Data is sixteen bits, msb first: a read returns the register, a write stores the value.
// [RULE_14] Reading a missing register returns all ones, and writing one changes no register.
// [RULE_15] The line is released between frames and back-to-back frames with no idle bit are accepted.
// [RULE_16] Incoming bits are taken on the rising clock edge and read bits change just after it.
// [RULE_17] Any frame error sends the block back to hunting for a preamble or delimiter, line undriven.
`ifndef SMF_MAP_SVH
`define SMF_MAP_SVH
`define SMF_PRE_ONES      32
`define SMF_HDR_BITS      12
`define SMF_TA_BITS       2
`define SMF_DATA_BITS     16
`define SMF_NUM_REGS      32
`define SMF_OP_READ       2'h2
`define SMF_OP_WRITE      2'h1
`define SMF_REG_STATUS    5'h01
`define SMF_REG_EXTCTL    5'h10
`define SMF_SKIP_BIT      6
`define SMF_OVR_BIT       15
`define SMF_PHYAD_LSB     6
`define SMF_PHYAD_MSB     10
`define SMF_IMPL_MASK     32'h000f_01ff
`define SMF_ABSENT_WORD   16'hffff
`define SMF_STRAP_DELAY   2'h2
`endif

// file: logic/smf_pkg.sv
// types for the serial management frame slave
package smf_pkg;
  typedef enum logic [2:0] {
    ST_HUNT  = 3'b000,
    ST_SFD   = 3'b001,
    ST_HDR   = 3'b010,
    ST_RTA   = 3'b011,
    ST_RDATA = 3'b100,
    ST_WTA   = 3'b101,
    ST_WDATA = 3'b110
  } smf_state_t;
endpackage

// file: logic/smf_regmem.sv
// management register store with registered read data
`timescale 1ns/1ps
module smf_regmem #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32,
  parameter int AW    = 5
) (
  // clock, reset, freeze
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  // write side
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  // read side
  input  wire logic             rd_en,
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
      rd_data <= '0;
    end else if (ce) begin
      if (wr_en) begin
        mem[wr_addr] <= wr_data;
      end
      if (rd_en) begin
        rd_data <= mem[rd_addr];
      end
    end
  end
endmodule // smf_regmem

// file: logic/smf_mgmt_slave.sv
// serial management frame slave: preamble, delimiter, opcode, address match, turnaround, data
`timescale 1ns/1ps
`include "smf_map.svh"
module smf_mgmt_slave #(
  parameter int          PRE_ONES  = `SMF_PRE_ONES,
  parameter logic [31:0] IMPL_MASK = `SMF_IMPL_MASK
) (
  // clock, reset, freeze
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic         ce,
  // management pins from the master
  input  wire logic         mdc,
  input  wire logic         mdio_in,
  output logic              mdio_out,
  output logic              mdio_oe,
  // address strap and status
  input  wire logic [4:0]   phy_addr_strap,
  output logic      [4:0]   phy_addr,
  output logic              preamble_skip_enable,
  output smf_pkg::smf_state_t frame_state
);
  import smf_pkg::*;

  localparam logic [5:0] PRE_CNT  = 6'(PRE_ONES);
  localparam logic [4:0] HDR_LAST = 5'(`SMF_HDR_BITS - 1);
  localparam logic [4:0] TA_LAST  = 5'(`SMF_TA_BITS - 1);
  localparam logic [4:0] DAT_LAST = 5'(`SMF_DATA_BITS - 1);
  localparam logic [4:0] DAT_END  = 5'(`SMF_DATA_BITS);

  function automatic logic reg_exists(input logic [4:0] addr);
    reg_exists = IMPL_MASK[addr];
  endfunction

  // pin synchronisers; the third mdc stage only remembers the previous level
  logic mdc_s1, mdc_s2, mdc_s3, dat_s1, dat_s2;
  logic [4:0] strap_s1, strap_s2;
  logic [1:0] strap_wait;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mdc_s1   <= 1'b0;
      mdc_s2   <= 1'b0;
      mdc_s3   <= 1'b0;
      dat_s1   <= 1'b1;
      dat_s2   <= 1'b1;
      strap_s1 <= 5'h00;
      strap_s2 <= 5'h00;
    end else if (ce) begin
      mdc_s1   <= mdc;
      mdc_s2   <= mdc_s1;
      mdc_s3   <= mdc_s2;
      dat_s1   <= mdio_in;
      dat_s2   <= dat_s1;
      strap_s1 <= phy_addr_strap;
      strap_s2 <= strap_s1;
    end
  end

  // the pins have no tie to the mac-side mode, so they stay live in every mode
  wire       mdc_rise = ce && mdc_s2 && !mdc_s3; // RULE_09 RULE_10 RULE_16
  wire       bit_in   = dat_s2;

  logic [5:0]  ones_cnt;
  logic [4:0]  bit_cnt;
  logic [11:0] hdr_sh;
  logic [15:0] data_sh;
  logic [4:0]  reg_addr;
  logic        override;
  logic [15:0] mem_rdata;

  // header decode on the word that includes the bit being taken now
  wire [11:0] hdr_next  = {hdr_sh[10:0], bit_in};
  wire [1:0]  hdr_op    = hdr_next[11:10];
  wire [4:0]  hdr_phy   = hdr_next[9:5];
  wire [4:0]  hdr_reg   = hdr_next[4:0];
  wire        op_read   = (hdr_op == `SMF_OP_READ); // RULE_05
  wire        op_write  = (hdr_op == `SMF_OP_WRITE); // RULE_05
  wire        phy_match = (hdr_phy == phy_addr); // RULE_07
  wire        hdr_done  = mdc_rise && (frame_state == ST_HDR) && (bit_cnt == HDR_LAST);
  wire        pre_ok    = preamble_skip_enable || (ones_cnt >= PRE_CNT); // RULE_01 RULE_02

  // write path; absent registers never see the strobe
  wire [15:0] wr_value  = {data_sh[14:0], bit_in};
  wire        wr_commit = mdc_rise && (frame_state == ST_WDATA) && (bit_cnt == DAT_LAST);
  wire        wr_ok     = wr_commit && reg_exists(reg_addr); // RULE_14
  wire        wr_status = wr_ok && (reg_addr == `SMF_REG_STATUS);
  wire        wr_extctl = wr_ok && (reg_addr == `SMF_REG_EXTCTL);

  // read word: live control bits overlay the stored word, absent registers read ones
  wire [15:0] ovl_status = {mem_rdata[15:`SMF_SKIP_BIT+1], preamble_skip_enable, mem_rdata[`SMF_SKIP_BIT-1:0]};
  wire [15:0] ovl_extctl = {override, mem_rdata[14:`SMF_PHYAD_MSB+1], phy_addr, mem_rdata[`SMF_PHYAD_LSB-1:0]};
  wire [15:0] rd_word    = !reg_exists(reg_addr)               ? `SMF_ABSENT_WORD : // RULE_14
                           (reg_addr == `SMF_REG_STATUS)       ? ovl_status :
                           (reg_addr == `SMF_REG_EXTCTL)       ? ovl_extctl : mem_rdata; // RULE_08

  smf_regmem #(
    .WIDTH (`SMF_DATA_BITS),
    .DEPTH (`SMF_NUM_REGS),
    .AW    (5)
  ) u_regmem (
    .clk     (ref_clk),
    .rst     (rst),
    .ce      (ce),
    .wr_en   (wr_ok), // RULE_13
    .wr_addr (reg_addr),
    .wr_data (wr_value),
    .rd_en   (hdr_done), // RULE_08
    .rd_addr (hdr_reg),
    .rd_data (mem_rdata)
  );

  smf_state_t  next_state;
  logic [5:0]  next_ones;
  logic [4:0]  next_cnt;
  logic [15:0] next_data;
  logic        next_oe;
  logic        next_out;

  always_comb begin
    next_state = frame_state;
    next_ones  = ones_cnt;
    next_cnt   = bit_cnt;
    next_data  = data_sh;
    next_oe    = mdio_oe;
    next_out   = mdio_out;
    if (mdc_rise) begin
      case (frame_state)
        ST_HUNT: begin
          // idle high line counts as preamble; any zero either opens a frame or restarts the count
          if (bit_in) begin
            if (ones_cnt < PRE_CNT) begin
              next_ones = ones_cnt + 6'h01; // RULE_01 RULE_11
            end
          end else if (pre_ok) begin
            next_state = ST_SFD; // RULE_01 RULE_02
          end else begin
            next_ones = 6'h00; // RULE_01
          end
        end
        ST_SFD: begin
          next_ones = 6'h00;
          next_cnt  = 5'h00;
          next_state = bit_in ? ST_HDR : ST_HUNT; // RULE_04 RULE_17
        end
        ST_HDR: begin
          if (bit_cnt == HDR_LAST) begin
            next_cnt = 5'h00;
            if (op_read && phy_match) begin
              next_state = ST_RTA; // RULE_05 RULE_07
            end else if (op_write && phy_match) begin
              next_state = ST_WTA; // RULE_05 RULE_07
            end else begin
              next_state = ST_HUNT; // RULE_06 RULE_07 RULE_17
            end
          end else begin
            next_cnt = bit_cnt + 5'h01;
          end
        end
        ST_RTA: begin
          // first turnaround bit stayed floating; drive the second as zero
          next_oe    = 1'b1; // RULE_12
          next_out   = 1'b0; // RULE_12
          next_data  = rd_word;
          next_cnt   = 5'h00;
          next_state = ST_RDATA;
        end
        ST_RDATA: begin
          if (bit_cnt == DAT_END) begin
            next_oe    = 1'b0; // RULE_15
            next_out   = 1'b0;
            next_state = ST_HUNT; // RULE_15
          end else begin
            next_out  = data_sh[15]; // RULE_13 RULE_16
            next_data = {data_sh[14:0], 1'b0};
            next_cnt  = bit_cnt + 5'h01;
          end
        end
        ST_WTA: begin
          // master owns both turnaround bits of a write; their values are not checked
          next_cnt   = (bit_cnt == TA_LAST) ? 5'h00 : bit_cnt + 5'h01;
          next_state = (bit_cnt == TA_LAST) ? ST_WDATA : ST_WTA;
        end
        ST_WDATA: begin
          next_data = wr_value; // RULE_13
          next_cnt  = bit_cnt + 5'h01;
          if (bit_cnt == DAT_LAST) begin
            next_cnt   = 5'h00;
            next_state = ST_HUNT; // RULE_15
          end
        end
        default: begin
          next_state = ST_HUNT;
          next_oe    = 1'b0;
          next_out   = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      frame_state <= ST_HUNT;
      ones_cnt    <= 6'h00;
      bit_cnt     <= 5'h00;
      data_sh     <= 16'h0000;
      mdio_oe     <= 1'b0;
      mdio_out    <= 1'b0;
    end else if (ce) begin
      frame_state <= next_state;
      ones_cnt    <= next_ones;
      bit_cnt     <= next_cnt;
      data_sh     <= next_data;
      mdio_oe     <= next_oe;
      mdio_out    <= next_out;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hdr_sh   <= 12'h000;
      reg_addr <= 5'h00;
    end else if (mdc_rise && frame_state == ST_HDR) begin
      hdr_sh   <= hdr_next;
      reg_addr <= hdr_done ? hdr_reg : reg_addr;
    end
  end

  // override arms the skip bit; clearing skip is always allowed
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      override             <= 1'b0;
      preamble_skip_enable <= 1'b0; // RULE_03
    end else if (ce) begin
      if (wr_extctl) begin
        override <= wr_value[`SMF_OVR_BIT]; // RULE_03
      end
      if (wr_status) begin
        preamble_skip_enable <= wr_value[`SMF_SKIP_BIT] & override; // RULE_03
      end
    end
  end

  // strap is caught a few cycles after release so it has crossed the synchroniser
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      strap_wait <= 2'h0;
      phy_addr   <= 5'h00;
    end else if (ce) begin
      if (strap_wait != 2'h3) begin
        strap_wait <= strap_wait + 2'h1;
      end
      if (strap_wait == `SMF_STRAP_DELAY) begin
        phy_addr <= strap_s2; // RULE_07
      end
    end
  end

  // checks run on the system clock; mdc_rise is the bit strobe, so a low clock enable holds off the checks that start on it
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_hunt_quiet: assert property (frame_state == ST_HUNT |-> !mdio_oe) else $error("line driven while hunting"); // RULE_15
  a_ta_float: assert property (frame_state == ST_RTA |-> !mdio_oe) else $error("first turnaround bit driven"); // RULE_12
  a_ta_zero: assert property (mdc_rise && frame_state == ST_RTA |=> mdio_oe && !mdio_out) // RULE_12
    else $error("second turnaround bit not driven low");
  a_pre_short: assert property (mdc_rise && frame_state == ST_HUNT && !bit_in && ones_cnt < PRE_CNT // RULE_01
    && !preamble_skip_enable |=> frame_state == ST_HUNT && ones_cnt == 6'h00) else $error("short preamble accepted");
  a_skip_open: assert property (mdc_rise && frame_state == ST_HUNT && !bit_in && preamble_skip_enable // RULE_02
    |=> frame_state == ST_SFD) else $error("frame without preamble not opened");
  a_bad_delim: assert property (mdc_rise && frame_state == ST_SFD && !bit_in |=> frame_state == ST_HUNT) // RULE_04
    else $error("bad delimiter not rejected");
  a_bad_opcode: assert property (hdr_done && !op_read && !op_write |=> frame_state == ST_HUNT [*4]) // RULE_06
    else $error("invalid opcode answered");
  a_addr_miss: assert property (hdr_done && !phy_match |=> !mdio_oe && frame_state == ST_HUNT) // RULE_07
    else $error("mismatched address answered");
  a_skip_guard: assert property (wr_status && !override |=> !preamble_skip_enable) // RULE_03
    else $error("skip bit set without override");
  a_absent_wr: assert property (wr_commit && !reg_exists(reg_addr) // RULE_14
    |=> u_regmem.mem[reg_addr] == $past(u_regmem.mem[reg_addr])) else $error("absent register written");
  a_read_msb: assert property (mdc_rise && frame_state == ST_RDATA && bit_cnt < DAT_END // RULE_13
    |=> mdio_oe && mdio_out == $past(data_sh[15])) else $error("read bit out of order");
  a_read_end: assert property (mdc_rise && frame_state == ST_RDATA && bit_cnt == DAT_END // RULE_15
    |=> !mdio_oe && frame_state == ST_HUNT) else $error("line not released after read");
  a_absent_rd: assert property (mdc_rise && frame_state == ST_RTA && !reg_exists(reg_addr) // RULE_14
    |=> data_sh == `SMF_ABSENT_WORD) else $error("absent register not read as ones");
  a_write_store: assert property (wr_ok |=> u_regmem.mem[reg_addr] == $past(wr_value)) // RULE_13
    else $error("write data not stored");
  a_oe_span: assert property (mdio_oe |-> frame_state == ST_RDATA) // RULE_15
    else $error("line driven outside read data");
  a_wta_quiet: assert property (mdc_rise && frame_state == ST_WTA |=> !mdio_oe) // RULE_12
    else $error("line driven in write turnaround");
  // the strap is taken once; later register writes must not move the address
  a_addr_hold: assert property (strap_wait == 2'h3 |=> $stable(phy_addr)) // RULE_07
    else $error("own address changed");

  c_read_frame: cover property (mdc_rise && frame_state == ST_RDATA && bit_cnt == DAT_END);
  c_write_frame: cover property (wr_ok);
  c_skip_on: cover property (wr_status && override && wr_value[`SMF_SKIP_BIT]);
  c_absent_read: cover property (mdc_rise && frame_state == ST_RTA && !reg_exists(reg_addr));
  c_skip_frame: cover property (mdc_rise && frame_state == ST_HUNT && !bit_in && preamble_skip_enable
    && ones_cnt < PRE_CNT);
endmodule // smf_mgmt_slave

// file: verif/smf_sta_model.sv
// station management model: drives the management clock and data line, samples read bits
`timescale 1ns/1ps
module smf_sta_model (
  // link pins
  output logic      mdc,
  output logic      sta_oe,
  output logic      sta_out,
  // resolved line and device enable
  input  wire logic mdio_wire,
  input  wire logic dev_oe
);
  initial begin
    mdc = 1'b0;
    sta_oe = 1'b0;
    sta_out = 1'b1;
  end
  // data changes while the clock is low and is taken at the rise
  task automatic bit_cyc(input logic drive, input logic v, output logic seen, output logic oe_seen);
    sta_oe = drive;
    sta_out = v;
    #32;
    seen = mdio_wire;
    oe_seen = dev_oe;
    mdc = 1'b1;
    #32;
    mdc = 1'b0;
  endtask
  // any op other than write releases the line after the header, so a wrong answer shows up
  task automatic frame(input int pre, input logic [1:0] sfd, input logic [1:0] op, input logic [4:0] phy,
                       input logic [4:0] rg, input logic [15:0] wd, output logic [15:0] rd,
                       output logic ta_z, output logic ta0);
    logic [13:0] hdr;
    logic        s;
    logic        o;
    logic        rdl;
    hdr = {sfd, op, phy, rg};
    rdl = (op != 2'b01);
    // caller starts frames 1 ns after a system clock edge; bit cycles are a whole number of clocks
    for (int i = 0; i < pre; i++) bit_cyc(1'b1, 1'b1, s, o);
    for (int i = 13; i >= 0; i--) bit_cyc(1'b1, hdr[i], s, o);
    bit_cyc(!rdl, 1'b1, s, o);
    ta_z = (o === 1'b0) && (s === 1'b1);
    bit_cyc(!rdl, 1'b0, s, o);
    ta0 = s;
    for (int i = 15; i >= 0; i--) begin
      bit_cyc(!rdl, wd[i], s, o);
      rd[i] = s;
    end
    sta_oe = 1'b0;
    if (rdl) bit_cyc(1'b0, 1'b1, s, o);
  endtask
endmodule // smf_sta_model

// file: verif/phy_serial_mgmt_frame_bench.sv
// self-checking bench for the serial management frame slave
`timescale 1ns/1ps
module phy_serial_mgmt_frame_bench;
  import smf_pkg::*;
  localparam int         PRE     = 32;
  localparam logic [4:0] MY_ADDR = 5'h0b;
  logic        ref_clk, rst, ce, mdc, sta_oe, sta_out, mdio_out, mdio_oe, preamble_skip_enable;
  logic [4:0]  strap, phy_addr;
  smf_state_t  frame_state;
  logic [15:0] rd;
  logic        tz, t0;
  int          fail_count, tests_run, oe_base;
  int          oe_hits = 0;
  wire         mdio_wire;
  // line has a pull-up, so an undriven line reads one
  assign mdio_wire = mdio_oe ? mdio_out : (sta_oe ? sta_out : 1'b1);
  smf_mgmt_slave #(.PRE_ONES(PRE)) smf_mgmt_slave_inst (
    .ref_clk(ref_clk), .rst(rst), .ce(ce), .mdc(mdc), .mdio_in(mdio_wire), .mdio_out(mdio_out),
    .mdio_oe(mdio_oe), .phy_addr_strap(strap), .phy_addr(phy_addr),
    .preamble_skip_enable(preamble_skip_enable), .frame_state(frame_state));
  smf_sta_model smf_sta_model_inst (
    .mdc(mdc), .sta_oe(sta_oe), .sta_out(sta_out), .mdio_wire(mdio_wire), .dev_oe(mdio_oe));
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) if (mdio_oe === 1'b1) oe_hits <= oe_hits + 1;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rd_reg(input logic [4:0] rg, output logic [15:0] v);
    smf_sta_model_inst.frame(PRE, 2'b01, 2'b10, MY_ADDR, rg, 16'h0000, v, tz, t0);
  endtask
  task automatic wr_reg(input int pre, input logic [4:0] rg, input logic [15:0] v);
    smf_sta_model_inst.frame(pre, 2'b01, 2'b01, MY_ADDR, rg, v, rd, tz, t0);
  endtask
  task automatic t_reset;
    check(mdio_oe, 1'b0);
    check(preamble_skip_enable, 1'b0);
    check(frame_state, ST_HUNT);
    check(phy_addr, MY_ADDR);
    $display("test reset done");
  endtask
  task automatic t_rw;
    wr_reg(PRE, 5'h00, 16'ha5c3);
    wr_reg(PRE, 5'h13, 16'h5a3c);
    rd_reg(5'h00, rd);
    check(rd, 16'ha5c3);
    check(tz, 1'b1);
    check(t0, 1'b0);
    rd_reg(5'h13, rd);
    check(rd, 16'h5a3c);
    check(mdio_oe, 1'b0);
    check(frame_state, ST_HUNT);
    $display("test write read done");
  endtask
  task automatic t_absent;
    wr_reg(PRE, 5'h09, 16'h1234);
    rd_reg(5'h09, rd);
    check(rd, 16'hffff);
    rd_reg(5'h1f, rd);
    check(rd, 16'hffff);
    rd_reg(5'h00, rd);
    check(rd, 16'ha5c3);
    $display("test absent done");
  endtask
  // bad opcodes, foreign address and bad delimiter must all stay silent
  task automatic t_reject;
    for (int i = 0; i < 4; i++) begin
      oe_base = oe_hits;
      smf_sta_model_inst.frame(PRE, (i == 3) ? 2'b00 : 2'b01, (i == 0) ? 2'b00 : ((i == 1) ? 2'b11 : 2'b10),
                               (i == 2) ? ~MY_ADDR : MY_ADDR, 5'h00, 16'h0000, rd, tz, t0);
      check(16'(oe_hits - oe_base), 16'h0000);
      check(rd, 16'hffff);
    end
    rd_reg(5'h00, rd);
    check(rd, 16'ha5c3);
    $display("test reject done");
  endtask
  // the write adds no idle bit and its delimiter cleared the count, so the short preamble is counted from nothing
  task automatic t_short;
    wr_reg(PRE, 5'h00, 16'h0ff0);
    oe_base = oe_hits;
    smf_sta_model_inst.frame(PRE - 1, 2'b01, 2'b10, MY_ADDR, 5'h00, 16'h0000, rd, tz, t0);
    check(16'(oe_hits - oe_base), 16'h0000);
    rd_reg(5'h00, rd);
    check(rd, 16'h0ff0);
    $display("test short preamble done");
  endtask
  task automatic t_skip;
    wr_reg(PRE, 5'h01, 16'h0040);
    check(preamble_skip_enable, 1'b0);
    wr_reg(PRE, 5'h10, 16'h8000);
    wr_reg(PRE, 5'h01, 16'h0040);
    check(preamble_skip_enable, 1'b1);
    wr_reg(0, 5'h00, 16'hbeef);
    smf_sta_model_inst.frame(0, 2'b01, 2'b10, MY_ADDR, 5'h00, 16'h0000, rd, tz, t0);
    check(rd, 16'hbeef);
    wr_reg(0, 5'h01, 16'h0000);
    check(preamble_skip_enable, 1'b0);
    $display("test preamble skip done");
  endtask
  task automatic final_report;
    $display("tests run %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    strap = MY_ADDR;
    fail_count = 0;
    tests_run = 0;
    oe_base = 0;
    repeat (3) @(posedge ref_clk);
    #1 rst = 1'b0;
    repeat (8) @(posedge ref_clk);
    #1;
    t_reset();
    t_rw();
    t_absent();
    t_reject();
    t_short();
    t_skip();
    final_report();
  end
  // about 22 frames of up to 4.2 us each are expected
  initial begin
    #200000;
    fail_count++;
    final_report();
  end
endmodule // phy_serial_mgmt_frame_bench
